// ### rtl/tsr_pkg.sv
// Constants shared by the temperature result and limit register block.
// Assumes an 8-bit register port driven by the serial bus engine in front.
//
// How it works
// - Reading any channel's integer byte copies that channel's fraction into its shadow.
// - Reading a fraction byte returns the shadow, matching the last integer read.
// - Each further integer byte read refreshes the shadow, fraction read or not.
// - Every result is held as eleven bits: integer byte plus fraction bits.
// - Integer byte carries plain binary weights, 128 down to 1.
// - Fraction is left-aligned: half, quarter, eighth; lower five bits read zero.
// - One shared hysteresis byte for all critical limits, reset to ten degrees.
// - Writable alert queue control byte, reset to its given value.
// - Upper-limit flags clear when read; reset to zero.
// - Lower-limit flags clear when read; reset to zero.
// - Critical-limit flags are read-only and a read leaves them alone.
// - Internal and third external channel critical limits, writable, reset 85 degrees.
// - Third external upper/lower limits in integer and fraction bytes, upper integer 85.
// - Ideality bytes for external channels one to three, reset to 1.008 code.
// - Beta settings for external channels one and two with their own resets.
// - Writable filter control for the first external channel, reset to zero.
// - Fixed identification bytes that writes never change.
package tsr_pkg;

    // Widths
    localparam int          TEMP_W     = 11;
    localparam int          FRAC_W     = 3;
    localparam int          INT_W      = 8;
    localparam int          NUM_CH     = 4;
    localparam logic [7:0]  FRAC_MASK  = 8'hE0;
    localparam logic [7:0]  ZERO_BYTE  = 8'h00;

    // Channel numbering, also the bit position in the flag bytes
    localparam int          CH_INT     = 0;
    localparam int          CH_EXT1    = 1;
    localparam int          CH_EXT2    = 2;
    localparam int          CH_EXT3    = 3;

    // Register offsets
    localparam logic [7:0]  A_INT_HI    = 8'h00;
    localparam logic [7:0]  A_EXT1_HI   = 8'h01;
    localparam logic [7:0]  A_EXT1_LO   = 8'h10;
    localparam logic [7:0]  A_INT_CRIT  = 8'h20;
    localparam logic [7:0]  A_HYST      = 8'h21;
    localparam logic [7:0]  A_QUEUE     = 8'h22;
    localparam logic [7:0]  A_EXT2_HI   = 8'h23;
    localparam logic [7:0]  A_EXT2_LO   = 8'h24;
    localparam logic [7:0]  A_BETA1     = 8'h25;
    localparam logic [7:0]  A_BETA2     = 8'h26;
    localparam logic [7:0]  A_IDEAL1    = 8'h27;
    localparam logic [7:0]  A_IDEAL2    = 8'h28;
    localparam logic [7:0]  A_INT_LO    = 8'h29;
    localparam logic [7:0]  A_EXT3_HI   = 8'h2A;
    localparam logic [7:0]  A_EXT3_LO   = 8'h2B;
    localparam logic [7:0]  A_E3_UP_INT = 8'h2C;
    localparam logic [7:0]  A_E3_LO_INT = 8'h2D;
    localparam logic [7:0]  A_E3_UP_FR  = 8'h2E;
    localparam logic [7:0]  A_E3_LO_FR  = 8'h2F;
    localparam logic [7:0]  A_EXT3_CRIT = 8'h30;
    localparam logic [7:0]  A_IDEAL3    = 8'h31;
    localparam logic [7:0]  A_UP_FLAGS  = 8'h35;
    localparam logic [7:0]  A_LO_FLAGS  = 8'h36;
    localparam logic [7:0]  A_CRIT_FLAGS= 8'h37;
    localparam logic [7:0]  A_FILTER    = 8'h40;
    localparam logic [7:0]  A_PART_ID   = 8'hFD;
    localparam logic [7:0]  A_MAKER_ID  = 8'hFE;
    localparam logic [7:0]  A_REV_ID    = 8'hFF;

    // Reset values
    localparam logic [7:0]  R_CRIT      = 8'h55;
    localparam logic [7:0]  R_HYST      = 8'h0A;
    localparam logic [7:0]  R_QUEUE     = 8'h70;
    localparam logic [7:0]  R_BETA1     = 8'h08;
    localparam logic [7:0]  R_BETA2     = 8'h07;
    localparam logic [7:0]  R_IDEAL     = 8'h12;
    localparam logic [7:0]  R_UP_INT    = 8'h55;
    localparam logic [7:0]  R_ZERO      = 8'h00;
    localparam logic [3:0]  R_FLAGS     = 4'h0;
    localparam logic [10:0] R_RESULT    = 11'h000;

endpackage

// ### rtl/tsr_chan_if.sv
// Link between the register block and one result/shadow channel.
// Assumes both ends share the block clock.
`timescale 1ns/100ps
interface tsr_chan_if;
    import tsr_pkg::*;
    logic              load;
    logic [TEMP_W-1:0] sample;
    logic              hi_rd;
    logic [INT_W-1:0]  hi_byte;
    logic [7:0]        lo_shadow;

    modport owner (output load, output sample, output hi_rd,
                   input hi_byte, input lo_shadow);
    modport chan  (input load, input sample, input hi_rd,
                   output hi_byte, output lo_shadow);
endinterface

// ### rtl/tsr_chan.sv
// One temperature channel: latest result and its shadowed fraction byte.
// Assumes load and hi_rd are single-cycle strobes from the register block.
`timescale 1ns/100ps
module tsr_chan
    import tsr_pkg::*;
(
    // Clock and control
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    // Channel link
    tsr_chan_if.chan  bus
);

    typedef struct packed {
        logic [TEMP_W-1:0] result;
        logic [7:0]        shadow;
    } tsr_chan_s;

    tsr_chan_s st_q;
    tsr_chan_s st_d;

    // Next state: new result, shadow copy on integer read
    always_comb begin
        st_d = st_q;
        if (bus.load) begin
            st_d.result = bus.sample;
        end
        if (bus.hi_rd) begin
            // Old result pairs with the integer byte returned this cycle
            st_d.shadow = {st_q.result[FRAC_W-1:0], {(8-FRAC_W){1'b0}}};
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '{result: R_RESULT, shadow: R_ZERO};
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // Integer part, binary weights 128..1
    assign bus.hi_byte   = st_q.result[TEMP_W-1:FRAC_W];
    assign bus.lo_shadow = st_q.shadow;

endmodule

// ### rtl/tsr_regs.sv
// Result, limit, status and identification register bank of a
// four-channel temperature monitor.
// Assumes the serial bus engine gives one-cycle read and write strobes
// with an 8-bit address, and the measurement core gives results and
// limit events synchronous to clk.
`timescale 1ns/100ps
module tsr_regs
    import tsr_pkg::*;
#(
    // Identification codes, values arbitrary
    parameter logic [7:0] PART_ID  = 8'hA6,
    parameter logic [7:0] MAKER_ID = 8'h3C,
    parameter logic [7:0] REV_ID   = 8'h01
)(
    // Clock and control
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    // Register port
    input  wire logic [7:0]             reg_addr,
    input  wire logic                   reg_rd,
    input  wire logic                   reg_wr,
    input  wire logic [7:0]             reg_wdata,
    output logic      [7:0]             reg_rdata,
    output logic                        reg_rvalid,
    // Measurement results, one strobe per channel
    input  wire logic [NUM_CH-1:0]              sample_load,
    input  wire logic [NUM_CH-1:0][TEMP_W-1:0]  sample_data,
    // Limit events from the comparators
    input  wire logic [NUM_CH-1:0]      upper_hit,
    input  wire logic [NUM_CH-1:0]      lower_hit,
    input  wire logic [NUM_CH-1:0]      critical_hit,
    // Settings toward the measurement core
    output logic      [7:0]             int_critical_limit,
    output logic      [7:0]             critical_hysteresis,
    output logic      [7:0]             alert_queue_control,
    output logic      [7:0]             ext1_beta_setting,
    output logic      [7:0]             ext2_beta_setting,
    output logic      [7:0]             ext1_ideality,
    output logic      [7:0]             ext2_ideality,
    output logic      [7:0]             ext3_ideality,
    output logic      [7:0]             ext3_upper_int,
    output logic      [7:0]             ext3_lower_int,
    output logic      [7:0]             ext3_upper_frac,
    output logic      [7:0]             ext3_lower_frac,
    output logic      [7:0]             ext3_critical_limit,
    output logic      [7:0]             ext1_filter_control
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------

    typedef struct packed {
        logic [7:0]        rdata;
        logic              rvalid;
        logic [7:0]        int_crit;
        logic [7:0]        hyst;
        logic [7:0]        queue;
        logic [7:0]        beta1;
        logic [7:0]        beta2;
        logic [7:0]        ideal1;
        logic [7:0]        ideal2;
        logic [7:0]        ideal3;
        logic [7:0]        e3_up_int;
        logic [7:0]        e3_lo_int;
        logic [7:0]        e3_up_fr;
        logic [7:0]        e3_lo_fr;
        logic [7:0]        e3_crit;
        logic [7:0]        filter;
        logic [NUM_CH-1:0] up_flags;
        logic [NUM_CH-1:0] lo_flags;
        logic [NUM_CH-1:0] crit_flags;
    } tsr_regs_s;

    localparam tsr_regs_s REGS_RST = '{
        rdata:      R_ZERO,
        rvalid:     1'b0,
        int_crit:   R_CRIT,
        hyst:       R_HYST,
        queue:      R_QUEUE,
        beta1:      R_BETA1,
        beta2:      R_BETA2,
        ideal1:     R_IDEAL,
        ideal2:     R_IDEAL,
        ideal3:     R_IDEAL,
        e3_up_int:  R_UP_INT,
        e3_lo_int:  R_ZERO,
        e3_up_fr:   R_ZERO,
        e3_lo_fr:   R_ZERO,
        e3_crit:    R_CRIT,
        filter:     R_ZERO,
        up_flags:   R_FLAGS,
        lo_flags:   R_FLAGS,
        crit_flags: R_FLAGS
    };

    tsr_regs_s st_q;
    tsr_regs_s st_d;

    // ------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------

    tsr_chan_if ch_if [NUM_CH] ();

    logic [NUM_CH-1:0]            hi_rd;
    logic [NUM_CH-1:0][INT_W-1:0] hi_byte;
    logic [NUM_CH-1:0][7:0]       lo_shadow;

    // Integer-byte read strobes per channel
    always_comb begin
        hi_rd          = '0;
        hi_rd[CH_INT]  = reg_rd && (reg_addr == A_INT_HI);
        hi_rd[CH_EXT1] = reg_rd && (reg_addr == A_EXT1_HI);
        hi_rd[CH_EXT2] = reg_rd && (reg_addr == A_EXT2_HI);
        hi_rd[CH_EXT3] = reg_rd && (reg_addr == A_EXT3_HI);
    end

    // One result/shadow holder per channel
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        assign ch_if[g].load   = sample_load[g];
        assign ch_if[g].sample = sample_data[g];
        assign ch_if[g].hi_rd  = hi_rd[g];
        assign hi_byte[g]      = ch_if[g].hi_byte;
        assign lo_shadow[g]    = ch_if[g].lo_shadow;

        tsr_chan u_chan (
            .clk (clk),
            .rst (rst),
            .ce  (ce),
            .bus (ch_if[g])
        );
    end

    // ------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------

    logic [7:0] rd_mux;

    // Register contents by address, unmapped reads give zero
    always_comb begin
        case (reg_addr)
            A_INT_HI:     rd_mux = hi_byte[CH_INT];
            A_EXT1_HI:    rd_mux = hi_byte[CH_EXT1];
            A_EXT2_HI:    rd_mux = hi_byte[CH_EXT2];
            A_EXT3_HI:    rd_mux = hi_byte[CH_EXT3];
            A_INT_LO:     rd_mux = lo_shadow[CH_INT];
            A_EXT1_LO:    rd_mux = lo_shadow[CH_EXT1];
            A_EXT2_LO:    rd_mux = lo_shadow[CH_EXT2];
            A_EXT3_LO:    rd_mux = lo_shadow[CH_EXT3];
            A_INT_CRIT:   rd_mux = st_q.int_crit;
            A_HYST:       rd_mux = st_q.hyst;
            A_QUEUE:      rd_mux = st_q.queue;
            A_BETA1:      rd_mux = st_q.beta1;
            A_BETA2:      rd_mux = st_q.beta2;
            A_IDEAL1:     rd_mux = st_q.ideal1;
            A_IDEAL2:     rd_mux = st_q.ideal2;
            A_IDEAL3:     rd_mux = st_q.ideal3;
            A_E3_UP_INT:  rd_mux = st_q.e3_up_int;
            A_E3_LO_INT:  rd_mux = st_q.e3_lo_int;
            A_E3_UP_FR:   rd_mux = st_q.e3_up_fr;
            A_E3_LO_FR:   rd_mux = st_q.e3_lo_fr;
            A_EXT3_CRIT:  rd_mux = st_q.e3_crit;
            A_UP_FLAGS:   rd_mux = {4'h0, st_q.up_flags};
            A_LO_FLAGS:   rd_mux = {4'h0, st_q.lo_flags};
            A_CRIT_FLAGS: rd_mux = {4'h0, st_q.crit_flags};
            A_FILTER:     rd_mux = st_q.filter;
            A_PART_ID:    rd_mux = PART_ID;
            A_MAKER_ID:   rd_mux = MAKER_ID;
            A_REV_ID:     rd_mux = REV_ID;
            default:      rd_mux = ZERO_BYTE;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    logic up_rd;
    logic lo_rd;

    assign up_rd = reg_rd && (reg_addr == A_UP_FLAGS);
    assign lo_rd = reg_rd && (reg_addr == A_LO_FLAGS);

    always_comb begin
        st_d        = st_q;
        st_d.rvalid = reg_rd;

        // Read data captured at the edge that takes the strobe
        if (reg_rd) begin
            st_d.rdata = rd_mux;
        end

        // Flags: a read clears, a new event in the same cycle wins
        if (up_rd) begin
            st_d.up_flags = R_FLAGS;
        end
        st_d.up_flags = st_d.up_flags | upper_hit;
        if (lo_rd) begin
            st_d.lo_flags = R_FLAGS;
        end
        st_d.lo_flags = st_d.lo_flags | lower_hit;

        // Critical flags follow the comparators, reads ignored
        st_d.crit_flags = critical_hit;

        // Writable settings; read-only addresses ignore writes
        if (reg_wr) begin
            case (reg_addr)
                A_INT_CRIT:  st_d.int_crit  = reg_wdata;
                A_HYST:      st_d.hyst      = reg_wdata;
                A_QUEUE:     st_d.queue     = reg_wdata;
                A_BETA1:     st_d.beta1     = reg_wdata;
                A_BETA2:     st_d.beta2     = reg_wdata;
                A_IDEAL1:    st_d.ideal1    = reg_wdata;
                A_IDEAL2:    st_d.ideal2    = reg_wdata;
                A_IDEAL3:    st_d.ideal3    = reg_wdata;
                A_E3_UP_INT: st_d.e3_up_int = reg_wdata;
                A_E3_LO_INT: st_d.e3_lo_int = reg_wdata;
                A_E3_UP_FR:  st_d.e3_up_fr  = reg_wdata & FRAC_MASK;
                A_E3_LO_FR:  st_d.e3_lo_fr  = reg_wdata & FRAC_MASK;
                A_EXT3_CRIT: st_d.e3_crit   = reg_wdata;
                A_FILTER:    st_d.filter    = reg_wdata;
                default: begin
                    // Identification, results and flags: writes dropped
                    st_d.rdata = st_d.rdata;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Synchronous reset; clock enable freezes everything
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= REGS_RST;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------------

    assign reg_rdata           = st_q.rdata;
    assign reg_rvalid          = st_q.rvalid;
    assign int_critical_limit  = st_q.int_crit;
    assign critical_hysteresis = st_q.hyst;
    assign alert_queue_control = st_q.queue;
    assign ext1_beta_setting   = st_q.beta1;
    assign ext2_beta_setting   = st_q.beta2;
    assign ext1_ideality       = st_q.ideal1;
    assign ext2_ideality       = st_q.ideal2;
    assign ext3_ideality       = st_q.ideal3;
    assign ext3_upper_int      = st_q.e3_up_int;
    assign ext3_lower_int      = st_q.e3_lo_int;
    assign ext3_upper_frac     = st_q.e3_up_fr;
    assign ext3_lower_frac     = st_q.e3_lo_fr;
    assign ext3_critical_limit = st_q.e3_crit;
    assign ext1_filter_control = st_q.filter;

endmodule

// ### tb/tsr_regs_props.sv
// Concurrent checks on the register port of the result and limit bank.
// Assumes it is bound to tsr_regs and sees only that module's ports.
`timescale 1ns/100ps
module tsr_regs_props
    import tsr_pkg::*;
#(
    parameter logic [7:0] PART_ID  = 8'hA6,
    parameter logic [7:0] MAKER_ID = 8'h3C,
    parameter logic [7:0] REV_ID   = 8'h01
)(
    // Clock and control
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              ce,
    // Register port
    input wire logic [7:0]        reg_addr,
    input wire logic              reg_rd,
    input wire logic              reg_wr,
    input wire logic [7:0]        reg_wdata,
    input wire logic [7:0]        reg_rdata,
    input wire logic              reg_rvalid,
    // Events and settings
    input wire logic [NUM_CH-1:0] critical_hit,
    input wire logic [7:0]        critical_hysteresis,
    input wire logic [7:0]        alert_queue_control
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Read answers, settings and flags
    // ------------------------------------------------------------
    a_rvalid_after_rd: assert property (ce && reg_rd |=> reg_rvalid)
        else $error("read strobe got no answer");
    a_rvalid_has_cause: assert property (reg_rvalid
        |-> $past(ce && reg_rd) || $past(!ce && reg_rvalid))
        else $error("answer without a read strobe");
    a_rdata_holds: assert property (!reg_rvalid && !$past(rst) |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_hyst_written: assert property (ce && reg_wr && reg_addr == 8'h21
        |=> critical_hysteresis == $past(reg_wdata))
        else $error("hysteresis write not applied");
    a_queue_written: assert property (ce && reg_wr && reg_addr == 8'h22
        |=> alert_queue_control == $past(reg_wdata))
        else $error("queue control write not applied");
    a_ident_fixed: assert property (ce && reg_rd && reg_addr inside {8'hFD, 8'hFE, 8'hFF}
        |=> reg_rdata == ($past(reg_addr) == 8'hFD ? PART_ID :
                          $past(reg_addr) == 8'hFE ? MAKER_ID : REV_ID))
        else $error("identification byte wrong");
    a_frac_low_zero: assert property (reg_rvalid && $past(reg_addr) inside
        {8'h10, 8'h24, 8'h29, 8'h2B} |-> reg_rdata[4:0] == 5'h00)
        else $error("fraction byte low bits not zero");
    a_crit_follows: assert property (ce && reg_rd && reg_addr == 8'h37 && $past(ce)
        && !$past(rst) |=> reg_rdata == {4'h0, $past(critical_hit, 2)})
        else $error("critical flags do not follow events");

    // Main scenarios seen
    c_hi_read: cover property (ce && reg_rd && reg_addr == 8'h01);
    c_hyst_write: cover property (ce && reg_wr && reg_addr == 8'h21);
    c_flag_seen: cover property (ce && reg_rd && reg_addr == 8'h35 ##1 reg_rdata != 8'h00);
endmodule

bind tsr_regs tsr_regs_props #(.PART_ID(PART_ID), .MAKER_ID(MAKER_ID), .REV_ID(REV_ID))
    u_props (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .critical_hit(critical_hit), .critical_hysteresis(critical_hysteresis),
    .alert_queue_control(alert_queue_control));

// ### tb/tsr_host_model.sv
// Host side of the register port: single reads and writes.
// Assumes the bank answers a read at the same edge that takes the strobe.
`timescale 1ns/100ps
module tsr_host_model (
    // Clock
    input  wire logic       clk,
    // Register port toward the bank
    output logic      [7:0] reg_addr,
    output logic            reg_rd,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    // ------------------------------------------------------------
    // Idle state and transfer tasks
    // ------------------------------------------------------------
    initial begin
        reg_addr  = 8'h00;
        reg_rd    = 1'b0;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
    end

    // One write; released lines show the inverse so stale values never pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge clk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask

    // One read; answer taken just after the edge that takes the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge clk);
        #1;
        d        = reg_rdata;
        v        = reg_rvalid;
        reg_rd   = 1'b0;
        reg_addr = ~a;
    endtask
endmodule

// ### tb/tsr_regs_tb_top.sv
// Self-checking bench for the result and limit register bank.
// Assumes the host model drives the register port; this top drives results.
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tsr_regs_tb_top;
    import tsr_pkg::*;
    localparam logic [7:0] P_ID = 8'h6B; // Arbitrary code
    localparam logic [7:0] M_ID = 8'h4E; // Arbitrary code
    localparam logic [7:0] V_ID = 8'h02; // Arbitrary code
    // Writable registers: address and reset value, same order as sv
    localparam logic [7:0] RW_A [14] = '{8'h20, 8'h21, 8'h22, 8'h25, 8'h26, 8'h27, 8'h28,
                                         8'h31, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h40};
    localparam logic [7:0] RW_R [14] = '{8'h55, 8'h0A, 8'h70, 8'h08, 8'h07, 8'h12, 8'h12,
                                         8'h12, 8'h55, 8'h00, 8'h00, 8'h00, 8'h55, 8'h00};
    localparam logic [7:0] HI_A [4]  = '{8'h00, 8'h01, 8'h23, 8'h2A};
    localparam logic [7:0] LO_A [4]  = '{8'h29, 8'h10, 8'h24, 8'h2B};
    logic                          clk, rst, ce;
    logic [NUM_CH-1:0]             sample_load, upper_hit, lower_hit, critical_hit;
    logic [NUM_CH-1:0][TEMP_W-1:0] sample_data;
    wire  [7:0]                    reg_addr, reg_wdata, reg_rdata;
    wire                           reg_rd, reg_wr, reg_rvalid;
    wire  [13:0][7:0]              sv;
    logic [7:0]                    rd_d;
    logic                          rd_v;
    int                            fail_count, n_tests, cyc;

    // ------------------------------------------------------------
    // Design, host and clock
    // ------------------------------------------------------------
    tsr_regs #(.PART_ID(P_ID), .MAKER_ID(M_ID), .REV_ID(V_ID)) DUT (
        .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .sample_load(sample_load), .sample_data(sample_data), .upper_hit(upper_hit),
        .lower_hit(lower_hit), .critical_hit(critical_hit),
        .int_critical_limit(sv[0]), .critical_hysteresis(sv[1]), .alert_queue_control(sv[2]),
        .ext1_beta_setting(sv[3]), .ext2_beta_setting(sv[4]), .ext1_ideality(sv[5]),
        .ext2_ideality(sv[6]), .ext3_ideality(sv[7]), .ext3_upper_int(sv[8]),
        .ext3_lower_int(sv[9]), .ext3_upper_frac(sv[10]), .ext3_lower_frac(sv[11]),
        .ext3_critical_limit(sv[12]), .ext1_filter_control(sv[13]));
    tsr_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Helpers and scenarios
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Read one register and compare answer and data
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rd_d, rd_v);
        `CHK(rd_v, 1'b1)
        `CHK(rd_d, e)
    endtask

    // Pulse one result load for a channel
    task automatic load(input int ch, input logic [10:0] v);
        @(posedge clk);
        #1;
        sample_data[ch] = v;
        sample_load[ch] = 1'b1;
        @(posedge clk);
        #1;
        sample_load = '0;
    endtask

    task automatic t_reset();
        for (int i = 0; i < 14; i++) begin
            `CHK(sv[i], RW_R[i])
            rc(RW_A[i], RW_R[i]);
        end
        for (int i = 0; i < 4; i++) begin
            rc(LO_A[i], 8'h00);
            rc(HI_A[i], 8'h00);
        end
        rc(8'h35, 8'h00);
        rc(8'h36, 8'h00);
        rc(8'h37, 8'h00);
        $display("test reset values done");
    endtask

    task automatic t_rw();
        logic [7:0] w;
        for (int i = 0; i < 14; i++) begin
            w = 8'hB3 ^ 8'(i);
            host.wr(RW_A[i], w);
            if (i == 10 || i == 11) w = w & FRAC_MASK;
            `CHK(sv[i], w)
            rc(RW_A[i], w);
        end
        host.wr(8'hFD, 8'h00);
        host.wr(8'h01, 8'hFF);
        rc(8'hFD, P_ID);
        rc(8'hFE, M_ID);
        rc(8'hFF, V_ID);
        rc(8'h01, 8'h00);
        ce = 1'b0;
        host.wr(8'h21, 8'h00);
        ce = 1'b1;
        `CHK(sv[1], 8'hB2)
        $display("test write and read back done");
    endtask

    task automatic t_shadow();
        for (int c = 0; c < 4; c++) begin
            load(c, {8'h40 + 8'(c), 3'b101});
            rc(HI_A[c], 8'h40 + 8'(c));
            load(c, {8'h91, 3'b011});
            repeat (20) @(posedge clk);
            rc(LO_A[c], 8'hA0);
            rc(HI_A[c], 8'h91);
            rc(LO_A[c], 8'h60);
            load(c, {8'h92, 3'b110});
            rc(HI_A[c], 8'h92);
            load(c, {8'h93, 3'b001});
            rc(HI_A[c], 8'h93);
            rc(LO_A[c], 8'h20);
        end
        $display("test shadow interlock done");
    endtask

    task automatic t_flags();
        @(posedge clk);
        #1;
        upper_hit    = 4'h5;
        lower_hit    = 4'hA;
        critical_hit = 4'h6;
        @(posedge clk);
        #1;
        upper_hit = '0;
        lower_hit = '0;
        rc(8'h35, 8'h05);
        rc(8'h35, 8'h00);
        rc(8'h36, 8'h0A);
        rc(8'h36, 8'h00);
        rc(8'h37, 8'h06);
        rc(8'h37, 8'h06);
        critical_hit = '0;
        $display("test limit flags done");
    endtask

    // Main sequence
    initial begin
        rst          = 1'b1;
        ce           = 1'b1;
        sample_load  = '0;
        sample_data  = '0;
        upper_hit    = '0;
        lower_hit    = '0;
        critical_hit = '0;
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_rw();
        t_shadow();
        t_flags();
        print_verdict();
    end
endmodule
